// file: verilog/pas_pkg.sv
// Package with register map, field positions and encodings for the PWM auto-shutdown block
package pas_pkg;
   // Register byte addresses (AHB-Lite word aligned)
   localparam logic [7:0] ADDR_SHUTDOWN_CTRL = 8'h00;
   localparam logic [7:0] ADDR_RESTART_CTRL  = 8'h04;
   localparam logic [7:0] ADDR_MODULE_CTRL   = 8'h08;
   localparam logic [7:0] ADDR_DUTY_HIGH     = 8'h0c;
   localparam logic [7:0] ADDR_PERIOD        = 8'h10;
   localparam logic [7:0] ADDR_TIMER_CTRL    = 8'h14;
   localparam logic [7:0] ADDR_STATUS        = 8'h18;
   // Shutdown control fields
   localparam int FLAG_BIT    = 7;
   localparam int SRC_LSB     = 4;
   localparam int AC_LSB      = 2;
   localparam int BD_LSB      = 0;
   localparam int RESTART_BIT = 7;
   // Module control fields
   localparam int POL_AC_BIT  = 0;
   localparam int POL_BD_BIT  = 1;
   localparam int DUTY_LO_LSB = 4;
   // Timer control / status fields and shutdown source bit positions
   localparam int TMR_ON_BIT  = 2;
   localparam int TFLAG_BIT   = 0;
   localparam int SRC_CMP1    = 0;
   localparam int SRC_CMP2    = 1;
   localparam int SRC_FAULT   = 2;
   // Safe state codes
   localparam logic [1:0] SAFE_LOW  = 2'h0;
   localparam logic [1:0] SAFE_HIGH = 2'h1;
   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [31:0] RDATA_ZERO = 32'h00000000;
   // AHB encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ    = 2'h3;
   localparam logic [1:0] HRESP_OKAY    = 2'h0;
endpackage

// file: verilog/pas_top.sv
// PWM auto-shutdown and restart block with AHB-Lite register slave
// Operation
// - Bit 7 shows outputs held in shutdown
// - Bits 6:4 select comparator and fault sources
// - A/C pair safe state low/high/tristate
// - B/D pair safe state low/high/tristate
// - Auto restart clears flag when cause ends
// - Without auto restart, software clears flag
// - Resume output at next period start
// - Flag writes ignored while condition active
// - Comparator causes are levels, block clearing
// - Writing 1 to flag forces shutdown
// - Per pair polarity from mode bits 1:0
// - Timer flag set at second period start
// - Duty from high byte plus bits 5:4
// - Sleep freezes timer and state; outputs stay combinational
// - Timer runs from hclk while clk_en is high
// - Reduced-pin variant keeps B/D field clear
// - Safe state applied without waiting clock
// - Flag at period start holds whole period
// - Fault pin is active low
//
// The AHB-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module pas_top #(
   parameter bit REDUCED_PINS = 1'b0
) (
   // Clock, reset and freeze
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        clk_en,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic [1:0]       hresp,
   // Shutdown sources
   input  wire logic        fault_in_n,
   input  wire logic        cmp1_out,
   input  wire logic        cmp2_out,
   // PWM inputs from the waveform generator
   input  wire logic        pwm_ac_raw,
   input  wire logic        pwm_bd_raw,
   // Bridge outputs, enable low while driving
   output logic             out_a,
   output logic             out_a_oe_n,
   output logic             out_b,
   output logic             out_b_oe_n,
   output logic             out_c,
   output logic             out_c_oe_n,
   output logic             out_d,
   output logic             out_d_oe_n,
   // Duty and timer state
   output logic [9:0]       duty_cycle,
   output logic             period_start
);
   // Register words, each byte in the low lane except the status timer in bits 15:8:
   // 0x00 shutdown control: flag, sources, pair safe states
   // 0x04 restart control: auto restart in bit 7
   // 0x08 module control: polarity bits 1:0, duty bits 5:4
   // 0x0c duty high byte
   // 0x10 period length
   // 0x14 timer control: run bit 2
   // 0x18 status: timer flag bit 0, timer bits 15:8
   // Unmapped words read zero and drop writes
   // Register state
   logic       shutdown_active_flag_q;
   logic [2:0] shutdown_source_sel_q;
   logic [1:0] pair_ac_safe_state_q;
   logic [1:0] pair_bd_safe_state_q;
   logic       auto_restart_en_q;
   logic [7:0] module_control_reg_q;
   logic [7:0] duty_high_byte_q;
   logic [7:0] period_reg_q;
   logic [7:0] timer_ctrl_q;
   logic [7:0] period_timer_q;
   logic       period_timer_flag_q;
   logic [1:0] period_count_q;
   logic       hold_q;
   logic [9:0] duty_q;
   // Bus data phase state
   logic       wr_pend_q;
   logic [7:0] wr_addr_q;
   logic [7:0] rd_addr_q;
   logic       rd_pend_q;
   // Synchronisers
   logic [2:0] src_meta_q;
   logic [2:0] src_sync_q;
   // Combinational signals
   logic       cond_async;
   logic       cond_sync;
   logic       flag_wr;
   logic       tflag_wr;
   logic       bus_take;
   logic       safe_now;
   logic [7:0] ctrl_byte;

   // Selects active sources from a source vector
   function automatic logic sel_cond(input logic [2:0] sel, input logic [2:0] src);
      sel_cond = |(sel & src);
   endfunction

   // Data-phase hit on one register word
   function automatic logic addr_hit(input logic pend, input logic [7:0] addr,
                                     input logic [7:0] reg_addr);
      addr_hit = pend && addr == reg_addr;
   endfunction

   // Drives one output pair given safe code and shutdown state
   function automatic logic [1:0] pair_drive(input logic shut, input logic [1:0] code,
                                             input logic pwm, input logic pol_low);
      if (!shut)
         pair_drive = {1'b0, pwm ^ pol_low};
      else if (code[1])
         pair_drive = 2'b10;
      else
         pair_drive = {1'b0, code == pas_pkg::SAFE_HIGH};
   endfunction

   // Source condition straight from pins for output gating
   assign cond_async = sel_cond(shutdown_source_sel_q, {~fault_in_n, cmp2_out, cmp1_out});
   // Synchronised condition for the flag logic
   assign cond_sync = sel_cond(shutdown_source_sel_q, src_sync_q);

   // Two-flop synchronisers, fault inverted after sync
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         src_meta_q <= 3'h4; // Fault pin idles high, no false cause after reset
         src_sync_q <= 3'h0;
      end else if (clk_en) begin
         src_meta_q <= {fault_in_n, cmp2_out, cmp1_out};
         src_sync_q <= {~src_meta_q[2], src_meta_q[1:0]};
      end
   end

   // AHB-Lite address phase capture
   // Transfer size is ignored: every access is a whole word
   assign bus_take = hsel && hready && (htrans == pas_pkg::HTRANS_NONSEQ || htrans == pas_pkg::HTRANS_SEQ);
   assign hreadyout = 1'b1;
   assign hresp = pas_pkg::HRESP_OKAY;

   // Data phase flags, one cycle after the address is taken
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
      end else if (clk_en) begin
         wr_pend_q <= bus_take && hwrite;
         rd_pend_q <= bus_take && !hwrite;
      end
   end

   // Address of the transfer in its data phase, held between transfers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_addr_q <= 8'h00;
         rd_addr_q <= 8'h00;
      end else if (clk_en && bus_take) begin
         wr_addr_q <= haddr;
         rd_addr_q <= haddr;
      end
   end

   // Write strobes for the bits with hardware side effects
   assign flag_wr  = addr_hit(wr_pend_q, wr_addr_q, pas_pkg::ADDR_SHUTDOWN_CTRL);
   assign tflag_wr = addr_hit(wr_pend_q, wr_addr_q, pas_pkg::ADDR_STATUS);

   // Configuration registers written in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         shutdown_source_sel_q <= 3'h0;
         pair_ac_safe_state_q  <= 2'h0;
         pair_bd_safe_state_q  <= 2'h0;
         auto_restart_en_q     <= 1'b0;
         module_control_reg_q  <= pas_pkg::RST_BYTE;
         duty_high_byte_q      <= pas_pkg::RST_BYTE;
         period_reg_q          <= pas_pkg::RST_BYTE;
         timer_ctrl_q          <= pas_pkg::RST_BYTE;
      end else if (clk_en && wr_pend_q) begin
         unique case (wr_addr_q)
            pas_pkg::ADDR_SHUTDOWN_CTRL: begin
               shutdown_source_sel_q <= hwdata[pas_pkg::SRC_LSB +: 3];
               pair_ac_safe_state_q  <= hwdata[pas_pkg::AC_LSB +: 2];
               pair_bd_safe_state_q  <= REDUCED_PINS ? 2'h0 : hwdata[pas_pkg::BD_LSB +: 2];
            end
            pas_pkg::ADDR_RESTART_CTRL: begin
               auto_restart_en_q <= hwdata[pas_pkg::RESTART_BIT];
            end
            pas_pkg::ADDR_MODULE_CTRL: begin
               module_control_reg_q <= hwdata[7:0];
            end
            pas_pkg::ADDR_DUTY_HIGH: begin
               duty_high_byte_q <= hwdata[7:0];
            end
            pas_pkg::ADDR_PERIOD: begin
               period_reg_q <= hwdata[7:0];
            end
            pas_pkg::ADDR_TIMER_CTRL: begin
               timer_ctrl_q <= hwdata[7:0];
            end
            default: ;
         endcase
      end
   end

   // Shutdown flag: set by condition or software, clear by hardware or software
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         shutdown_active_flag_q <= 1'b0;
      end else if (clk_en) begin
         if (cond_sync)
            shutdown_active_flag_q <= 1'b1;
         else if (flag_wr)
            shutdown_active_flag_q <= hwdata[pas_pkg::FLAG_BIT];
         else if (auto_restart_en_q)
            shutdown_active_flag_q <= 1'b0;
      end
   end

   // Period timer counts up to the period value, then restarts
   assign period_start = timer_ctrl_q[pas_pkg::TMR_ON_BIT] && clk_en && period_timer_q == period_reg_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         period_timer_q <= 8'h00;
      end else if (clk_en && timer_ctrl_q[pas_pkg::TMR_ON_BIT]) begin
         period_timer_q <= period_start ? 8'h00 : period_timer_q + 8'h01;
      end
   end

   // Periods seen since the timer was switched on, saturating at two
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         period_count_q <= 2'h0;
      end else if (clk_en) begin
         if (!timer_ctrl_q[pas_pkg::TMR_ON_BIT])
            period_count_q <= 2'h0;
         else if (period_start && period_count_q != 2'h2)
            period_count_q <= period_count_q + 2'h1;
      end
   end

   // Timer flag at second period start, set wins over clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         period_timer_flag_q <= 1'b0;
      end else if (clk_en) begin
         if (period_start && period_count_q != 2'h0)
            period_timer_flag_q <= 1'b1;
         else if (tflag_wr && hwdata[pas_pkg::TFLAG_BIT])
            period_timer_flag_q <= 1'b0;
      end
   end

   // Output hold, released only at a period boundary
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hold_q <= 1'b0;
      end else if (clk_en) begin
         if (shutdown_active_flag_q)
            hold_q <= 1'b1;
         else if (period_start)
            hold_q <= 1'b0;
      end
   end

   // Duty latch update at each period boundary
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         duty_q <= 10'h000;
      end else if (clk_en && period_start) begin
         duty_q <= {duty_high_byte_q, module_control_reg_q[pas_pkg::DUTY_LO_LSB +: 2]};
      end
   end
   assign duty_cycle = duty_q;

   // Outputs gated combinationally by the raw condition
   assign safe_now = cond_async || shutdown_active_flag_q || hold_q;
   always_comb begin
      logic [1:0] ac;
      logic [1:0] bd;
      ac = pair_drive(safe_now, pair_ac_safe_state_q, pwm_ac_raw,
                      module_control_reg_q[pas_pkg::POL_AC_BIT]);
      bd = pair_drive(safe_now, pair_bd_safe_state_q, pwm_bd_raw,
                      module_control_reg_q[pas_pkg::POL_BD_BIT]);
      out_a      = ac[0];
      out_c      = ac[0];
      out_a_oe_n = ac[1];
      out_c_oe_n = ac[1];
      out_b      = bd[0];
      out_d      = bd[0];
      out_b_oe_n = bd[1];
      out_d_oe_n = bd[1];
      // Reduced-pin variant has only the A pin; B, C and D stay released
      if (REDUCED_PINS) begin
         out_b_oe_n = 1'b1;
         out_c_oe_n = 1'b1;
         out_d_oe_n = 1'b1;
      end
   end

   // Read data mux
   assign ctrl_byte = {shutdown_active_flag_q, shutdown_source_sel_q,
                       pair_ac_safe_state_q, pair_bd_safe_state_q};
   always_comb begin
      hrdata = pas_pkg::RDATA_ZERO;
      if (rd_pend_q) begin
         unique case (rd_addr_q)
            pas_pkg::ADDR_SHUTDOWN_CTRL: begin
               hrdata = {24'h000000, ctrl_byte};
            end
            pas_pkg::ADDR_RESTART_CTRL: begin
               hrdata = {24'h000000, auto_restart_en_q, 7'h00};
            end
            pas_pkg::ADDR_MODULE_CTRL: begin
               hrdata = {24'h000000, module_control_reg_q};
            end
            pas_pkg::ADDR_DUTY_HIGH: begin
               hrdata = {24'h000000, duty_high_byte_q};
            end
            pas_pkg::ADDR_PERIOD: begin
               hrdata = {24'h000000, period_reg_q};
            end
            pas_pkg::ADDR_TIMER_CTRL: begin
               hrdata = {24'h000000, timer_ctrl_q};
            end
            pas_pkg::ADDR_STATUS: begin
               hrdata = {16'h0000, period_timer_q, 7'h00, period_timer_flag_q};
            end
            default:                     hrdata = pas_pkg::RDATA_ZERO;
         endcase
      end
   end
endmodule
`default_nettype wire

// file: testbench/pas_top_monitor.sv
// Assertion checker for the PWM auto-shutdown block ports
`timescale 1ns/1ps
`default_nettype none
module pas_top_monitor (
   // Clock, reset and bus
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        clk_en,
   input wire logic        hsel,
   input wire logic [7:0]  haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic [1:0]  hresp,
   // Sources and bridge outputs
   input wire logic        fault_in_n,
   input wire logic        cmp1_out,
   input wire logic        out_a,
   input wire logic        out_a_oe_n,
   input wire logic        out_c_oe_n,
   input wire logic        out_b,
   input wire logic        out_b_oe_n,
   input wire logic        out_d,
   input wire logic [9:0]  duty_cycle,
   input wire logic        period_start
);
   logic       acc_q;
   logic       wr_q;
   logic [6:0] cfg_q;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Shadow of source and safe-state fields, taken in the write data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acc_q <= 1'b0;
         wr_q <= 1'b0;
         cfg_q <= 7'h00;
      end else begin
         acc_q <= hsel && hready && htrans[1];
         wr_q <= hsel && hready && htrans[1] && hwrite && haddr == 8'h00;
         if (wr_q)
            cfg_q <= hwdata[6:0];
      end
   end
   property p_okay; hreadyout && hresp == 2'h0; endproperty
   a_okay: assert property (p_okay) else $error("slave not ready or not OKAY");
   property p_rdata; !acc_q |-> hrdata == 32'h0; endproperty
   a_rdata: assert property (p_rdata) else $error("read data outside data phase");
   property p_ac_hi; !fault_in_n && cfg_q[6] && cfg_q[3:2] == 2'h1 |-> out_a && !out_a_oe_n; endproperty
   a_ac_hi: assert property (p_ac_hi) else $error("pair AC not driven high on fault");
   property p_ac_tri; !fault_in_n && cfg_q[6] && cfg_q[3] |-> out_a_oe_n && out_c_oe_n; endproperty
   a_ac_tri: assert property (p_ac_tri) else $error("pair AC not released on fault");
   property p_bd_hi; !fault_in_n && cfg_q[6] && cfg_q[1:0] == 2'h1 |-> out_b && out_d && !out_b_oe_n; endproperty
   a_bd_hi: assert property (p_bd_hi) else $error("pair BD not driven high on fault");
   property p_cmp; cmp1_out && cfg_q[4] && cfg_q[3:2] == 2'h1 |-> out_a && !out_a_oe_n; endproperty
   a_cmp: assert property (p_cmp) else $error("comparator one did not shut down");
   property p_duty; $changed(duty_cycle) |-> $past(period_start); endproperty
   a_duty: assert property (p_duty) else $error("duty changed off period start");
   property p_freeze; !clk_en |=> $stable(duty_cycle); endproperty
   a_freeze: assert property (p_freeze) else $error("duty changed while frozen");
   c_fault: cover property (!fault_in_n && cfg_q[6]);
   c_cmp: cover property (cmp1_out && cfg_q[4]);
   c_duty: cover property ($changed(duty_cycle));
endmodule
bind pas_top pas_top_monitor u_mon (.*);
`default_nettype wire

// file: testbench/pas_src_model.sv
// Model of fault pin, comparators and raw PWM drive facing the block
`timescale 1ns/1ps
`default_nettype none
module pas_src_model (
   // Clock and reset
   input  wire logic       hclk,
   input  wire logic       hresetn,
   // Bench requests: bit 0 comparator one, bit 1 comparator two, bit 2 fault
   input  wire logic [2:0] src_req,
   // Shutdown sources
   output logic            fault_in_n,
   output logic            cmp1_out,
   output logic            cmp2_out,
   // Raw waveforms
   output logic            pwm_ac_raw,
   output logic            pwm_bd_raw
);
   logic [2:0] cnt_q;
   // Pulled-up fault pin, pulled low only while a fault is requested
   assign fault_in_n = ~src_req[2];
   assign cmp1_out = src_req[0];
   assign cmp2_out = src_req[1];
   // Waveforms at unequal rates so a swapped pair shows
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q <= 3'h0;
      end else begin
         cnt_q <= cnt_q + 3'h1;
      end
   end
   assign pwm_ac_raw = cnt_q[0];
   assign pwm_bd_raw = cnt_q[1];
endmodule
`default_nettype wire

// file: testbench/pas_top_test.sv
// Self-checking testbench for the PWM auto-shutdown block
`timescale 1ns/1ps
`default_nettype none
module pas_top_test;
   logic        hclk, hresetn, clk_en, hsel, hwrite, hreadyout, fault_in_n, cmp1_out, cmp2_out;
   logic        pwm_ac_raw, pwm_bd_raw, out_a, out_a_oe_n, out_b, out_b_oe_n, out_c, out_c_oe_n;
   logic        out_d, out_d_oe_n, period_start;
   logic [7:0]  haddr;
   logic [1:0]  htrans, hresp;
   logic [31:0] hwdata, hrdata, rd_s, r, t;
   logic [9:0]  duty_cycle;
   logic [2:0]  src_req;
   int          n_fail, compares, c, s;
   pas_top dut (.hsize(3'h2), .hready(hreadyout), .*);
   pas_src_model u_src (.*);
   // Clock and read data taken at the answering edge
   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   always @(posedge hclk) rd_s <= hrdata;
   task automatic complete_run;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Bounded wait for hready at a rising edge
   task automatic wrdy;
      int i;
      i = 0;
      do begin
         @(posedge hclk);
         i++;
      end while (hreadyout !== 1'b1 && i < 64);
      if (i >= 64) begin
         n_fail++;
         complete_run;
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      wrdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wrdy;
      #1 r = rd_s;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(r, e);
   endtask
   // Change the sources, then let the synchronisers settle
   task automatic src(input logic [2:0] v);
      @(posedge hclk);
      src_req <= v;
      repeat (4) @(posedge hclk);
   endtask
   // Bounded wait for a period start; ends at the falling edge after it
   task automatic wps;
      int i;
      i = 0;
      do begin
         @(negedge hclk);
         i++;
      end while (period_start !== 1'b1 && i < 200);
      if (i >= 200) begin
         n_fail++;
         complete_run;
      end
      @(negedge hclk);
   endtask
   initial begin
      hresetn = 1'b0;
      clk_en = 1'b1;
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      src_req = 3'h0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      rdc(8'h00, 32'h0);
      rdc(8'h40, 32'h0);
      $display("test reset done");
      // Period, duty and timer set up before any pin
      bus(1'b1, 8'h10, 32'h7);
      bus(1'b1, 8'h0c, 32'h5a);
      bus(1'b1, 8'h08, 32'h30);
      bus(1'b1, 8'h14, 32'h4);
      wps;
      chk(32'(duty_cycle), 32'h16b);
      wps;
      wps;
      bus(1'b0, 8'h18, 32'h0);
      chk(32'(r[0]), 32'h1);
      bus(1'b1, 8'h18, 32'h1);
      $display("test duty done");
      // Fault with AC released and BD high, no auto restart
      src(3'h4);
      bus(1'b1, 8'h00, 32'h49);
      @(negedge hclk);
      chk(32'({out_a_oe_n, out_c_oe_n, out_b, out_d, out_b_oe_n, out_d_oe_n}), 32'h3c);
      rdc(8'h00, 32'hc9);
      bus(1'b1, 8'h00, 32'h49);
      rdc(8'h00, 32'hc9);
      src(3'h0);
      rdc(8'h00, 32'hc9);
      wps;
      bus(1'b1, 8'h00, 32'h49);
      @(negedge hclk);
      chk(32'(out_a_oe_n), 32'h1);
      wps;
      chk(32'({out_a_oe_n, out_a ^ pwm_ac_raw}), 32'h0);
      rdc(8'h00, 32'h49);
      $display("test fault done");
      // Every source code against every single source, auto restart on
      bus(1'b1, 8'h04, 32'h80);
      for (c = 0; c < 8; c++) begin
         for (s = 0; s < 3; s++) begin
            bus(1'b1, 8'h00, {25'h0, c[2:0], 4'h4});
            src(3'(1 << s));
            rdc(8'h00, {24'h0, c[s], c[2:0], 4'h4});
            src(3'h0);
            rdc(8'h00, {25'h0, c[2:0], 4'h4});
         end
      end
      $display("test sources done");
      // Forced shutdown by software with no source selected
      bus(1'b1, 8'h04, 32'h0);
      bus(1'b1, 8'h00, 32'h80);
      rdc(8'h00, 32'h80);
      @(negedge hclk);
      chk(32'({out_a, out_c, out_a_oe_n, out_c_oe_n}), 32'h0);
      bus(1'b1, 8'h00, 32'h0);
      // Both pairs active low
      bus(1'b1, 8'h08, 32'h3);
      wps;
      chk(32'({out_a ^ pwm_ac_raw, out_c ^ pwm_ac_raw, out_b ^ pwm_bd_raw, out_d ^ pwm_bd_raw}), 32'hf);
      $display("test force and polarity done");
      // Sleep freezes the period timer: only four running edges lie between the two reads
      bus(1'b0, 8'h18, 32'h0);
      t = r;
      @(posedge hclk);
      clk_en <= 1'b0;
      repeat (5) @(posedge hclk);
      clk_en <= 1'b1;
      bus(1'b0, 8'h18, 32'h0);
      chk(32'(r[15:8]), 32'((t[15:8] + 8'h04) & 8'h07));
      $display("test freeze done");
      complete_run;
   end
endmodule
`default_nettype wire
